// >>> rtl/sarseq_defines.svh
// Purpose: constants of the scan sequencer: register offsets, fields, reset values, timing
// Assumes: apb with 32-bit data, one aligned word per register, 10 MHz clock
// Notes: all offsets are byte addresses
//
// How it works
// - ten bit result built bit by bit from comparator answer on one of eight inputs
// - fixed single: one conversion, stored in that channel's pair, then completion
// - fixed continuous: results fill the eight pairs in turn, wrapping, until stopped
// - fixed continuous: completion after every four or every eight conversions
// - scan single: each enabled channel converted once into its own pair
// - scan modes: completion after all channels, or after first four and the rest
// - scan single with one channel acts as fixed single
// - scan continuous: restart at first channel, results wrap through eight pairs
// - dual mode alternates two inputs, into even pairs then odd pairs
// - dual mode: completion after each four or eight conversions
// - single step: completion per channel, then wait for next start event
// - timer start on timer zero overflow, ignored while busy
// - immediate start begins a conversion at once
// - pin edge start, rising or falling, ignored while busy
// - every start source works with every operating mode
// - result checked against limits; inside (equal counts) or outside selectable
// - boundary interrupt suppressed while its enable is clear
// - outside check done early on the top four bits
// - otherwise the check repeats after the top eight bits
// - boundary status flags the channel that caused a boundary event
// - converter clock divided from input clock by one to eight
// - ten bit conversion takes four microseconds at 10 MHz divided by four
// - runs in idle, stopped in power down
`ifndef SARSEQ_DEFINES_SVH
`define SARSEQ_DEFINES_SVH
`define SARSEQ_OFF_CTRL 12'h000
`define SARSEQ_OFF_CHSEL 12'h004
`define SARSEQ_OFF_LIMIT 12'h008
`define SARSEQ_OFF_STAT 12'h00C
`define SARSEQ_OFF_BND 12'h010
`define SARSEQ_OFF_RES0 12'h020
// ctrl fields
`define SARSEQ_CTRL_MODE_LSB 0
`define SARSEQ_CTRL_START_LSB 4
`define SARSEQ_CTRL_EDGE_BIT 6
`define SARSEQ_CTRL_RUN_BIT 7
`define SARSEQ_CTRL_DIV_LSB 8
`define SARSEQ_CTRL_GRP8_BIT 11
`define SARSEQ_CTRL_IEN_BIT 12
`define SARSEQ_CTRL_BIEN_BIT 13
`define SARSEQ_CTRL_BOUT_BIT 14
`define SARSEQ_CTRL_BIT_ENB 15
`define SARSEQ_CTRL_RST 32'h0000_0000
`define SARSEQ_LIMIT_RST 32'h03FF_0000
// status: bit 0 done, bit 1 boundary, bit 2 busy; write one to clear bits 0 and 1, busy is read only
`define SARSEQ_STAT_DONE 0
`define SARSEQ_STAT_BND 1
`define SARSEQ_STAT_BUSY 2
// conversion timing: 10 bit clocks, sampling during the first of them
`define SARSEQ_CONV_US 4
`define SARSEQ_BITS 10
`endif

// >>> rtl/sarseq_pkg.sv
// Purpose: types of the scan sequencer
// Assumes: included defines
// Notes: none
package sarseq_pkg;
    typedef enum logic [2:0]
    {
        SARSEQ_FIX_ONE = 3'h0,
        SARSEQ_FIX_CONT = 3'h1,
        SARSEQ_SCAN_ONE = 3'h2,
        SARSEQ_SCAN_CONT = 3'h3,
        SARSEQ_DUAL = 3'h4,
        SARSEQ_STEP = 3'h5
    } sarseq_mode_t;
    typedef enum logic [1:0]
    {
        SARSEQ_SRC_TIMER = 2'h0,
        SARSEQ_SRC_NOW = 2'h1,
        SARSEQ_SRC_EDGE = 2'h2
    } sarseq_src_t;
    // analog side bundle
    typedef struct packed
    {
        logic [2:0] chan;
        logic [9:0] dac;
        logic sample;
    } sarseq_ana_t;
    typedef enum logic [2:0]
    {
        SARSEQ_IDLE = 3'b001,
        SARSEQ_CONV = 3'b010,
        SARSEQ_WAIT = 3'b100
    } sarseq_state_t;
endpackage : sarseq_pkg

// >>> rtl/sarseq_top.sv
// Purpose: successive approximation scan sequencer with apb registers
// Assumes: comparator answer valid in the same clock the dac changes
// Notes: one bit resolved per converter clock tick
//
// Decided for this implementation: the address map and the APB slave port.
`include "sarseq_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module sarseq_top
(
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer0_ovf,
    input wire logic edge_start_pin,
    input wire logic cmp_above,
    input wire logic power_down,
    output sarseq_pkg::sarseq_ana_t ana,
    output logic done_irq,
    output logic bnd_irq
);
    import sarseq_pkg::*;

    logic [31:0] ctrl_ff;
    logic [7:0] chsel_ff;
    logic [31:0] limit_ff;
    logic done_ff, bndf_ff;
    logic [7:0] bnd_ff;
    logic [9:0] res_ff [0:7];
    sarseq_state_t state_ff;
    logic [9:0] sar_ff;
    logic [3:0] bit_ff;
    logic [2:0] chan_ff, slot_ff, div_ff;
    logic [3:0] cnt_ff, nconv_ff;
    logic pin_ff, dual_ff, early_ff, stopped_ff;

    sarseq_mode_t mode;
    sarseq_src_t src;
    logic run, tick, wr, rd, go, finish, wr_done_clr;
    logic [9:0] lo_lim, hi_lim, trial, result;
    logic [2:0] nxt_chan;
    logic first_chan_found, last_scan, one_shot;

    assign mode = sarseq_mode_t'(ctrl_ff[`SARSEQ_CTRL_MODE_LSB +: 3]);
    assign src = sarseq_src_t'(ctrl_ff[`SARSEQ_CTRL_START_LSB +: 2]);
    assign run = ctrl_ff[`SARSEQ_CTRL_RUN_BIT] & ctrl_ff[`SARSEQ_CTRL_BIT_ENB];
    assign lo_lim = limit_ff[9:0];
    assign hi_lim = limit_ff[25:16];
    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;
    assign pready = 1'b1;

    // next enabled channel above a given one, wrapping; used by scan and start
    function automatic logic [2:0] next_sel(input logic [7:0] sel, input logic [2:0] cur);
        logic [2:0] c;
        logic [2:0] r;
        r = cur;
        for (int i = 7; i >= 1; i--)
        begin
            c = cur + i[2:0];
            if (sel[c])
                r = c;
        end
        return r;
    endfunction : next_sel

    // outside test on any width of msbs; equality counts as inside
    function automatic logic outside(input logic [9:0] v, input logic [9:0] mask);
        return ((v & mask) < (lo_lim & mask)) | ((v & mask) > (hi_lim & mask));
    endfunction : outside

    // converter clock divider, 1..8; halts in power down so nothing advances
    always_ff @(posedge clk)
    begin
        if (srst || state_ff == SARSEQ_IDLE)
            div_ff <= 3'h0;
        else if (!power_down)
            div_ff <= (div_ff == ctrl_ff[`SARSEQ_CTRL_DIV_LSB +: 3]) ? 3'h0 : div_ff + 3'h1;
    end
    assign tick = !power_down && div_ff == ctrl_ff[`SARSEQ_CTRL_DIV_LSB +: 3];

    // start events; busy state blocks them because go is only looked at in idle/wait
    always_ff @(posedge clk)
    begin
        if (srst)
            pin_ff <= 1'b0;
        else
            pin_ff <= edge_start_pin;
    end
    always_comb
    begin
        case (src)
            SARSEQ_SRC_TIMER: go = timer0_ovf;
            SARSEQ_SRC_NOW: go = 1'b1;
            SARSEQ_SRC_EDGE: go = ctrl_ff[`SARSEQ_CTRL_EDGE_BIT] ? (edge_start_pin & ~pin_ff)
                : (~edge_start_pin & pin_ff);
            default: go = 1'b0;
        endcase
    end

    assign first_chan_found = |chsel_ff;
    assign nxt_chan = next_sel(chsel_ff, chan_ff);
    // last channel of a scan pass: wrapping back means pass complete
    assign last_scan = nxt_chan <= chan_ff;
    assign one_shot = mode == SARSEQ_FIX_ONE || mode == SARSEQ_SCAN_ONE;
    assign trial = sar_ff | (10'h200 >> bit_ff);
    assign result = cmp_above ? trial : sar_ff;
    assign finish = state_ff == SARSEQ_CONV && tick && bit_ff == 4'(`SARSEQ_BITS - 1);

    // sequencer: idle, converting, waiting for next start in step mode
    always_ff @(posedge clk)
    begin
        if (srst || !run)
        begin
            state_ff <= SARSEQ_IDLE;
            bit_ff <= 4'h0;
            sar_ff <= 10'h000;
            slot_ff <= 3'h0;
            cnt_ff <= 4'h0;
            dual_ff <= 1'b0;
            chan_ff <= 3'h0;
            nconv_ff <= 4'h0;
            stopped_ff <= 1'b0;
        end
        else
        begin
            case (state_ff)
                SARSEQ_IDLE:
                begin
                    if (go && !stopped_ff && first_chan_found)
                    begin
                        state_ff <= SARSEQ_CONV;
                        chan_ff <= chsel_ff[0] ? 3'h0 : next_sel(chsel_ff, 3'h0);
                        dual_ff <= 1'b0;
                        slot_ff <= 3'h0;
                        cnt_ff <= 4'h0;
                        nconv_ff <= 4'h0;
                    end
                end
                SARSEQ_WAIT:
                begin
                    if (go)
                        state_ff <= SARSEQ_CONV;
                end
                SARSEQ_CONV:
                begin
                    if (tick)
                    begin
                        sar_ff <= result;
                        bit_ff <= bit_ff + 4'h1;
                    end
                    if (finish)
                    begin
                        bit_ff <= 4'h0;
                        sar_ff <= 10'h000;
                        slot_ff <= slot_ff + 3'h1;
                        cnt_ff <= (cnt_ff == (ctrl_ff[`SARSEQ_CTRL_GRP8_BIT] ? 4'h7 : 4'h3))
                            ? 4'h0 : cnt_ff + 4'h1;
                        nconv_ff <= nconv_ff + 4'h1;
                        case (mode)
                            SARSEQ_FIX_ONE:
                            begin
                                state_ff <= SARSEQ_IDLE;
                                stopped_ff <= 1'b1;
                            end
                            SARSEQ_FIX_CONT: ;
                            SARSEQ_DUAL:
                            begin
                                dual_ff <= ~dual_ff;
                                chan_ff <= dual_ff ? (chsel_ff[0] ? 3'h0 : next_sel(chsel_ff, 3'h0))
                                    : nxt_chan;
                            end
                            SARSEQ_STEP:
                            begin
                                chan_ff <= nxt_chan;
                                state_ff <= SARSEQ_WAIT;
                            end
                            default:
                            begin
                                chan_ff <= nxt_chan;
                                if (mode == SARSEQ_SCAN_ONE && last_scan)
                                begin
                                    state_ff <= SARSEQ_IDLE;
                                    stopped_ff <= 1'b1;
                                end
                                if (last_scan)
                                    nconv_ff <= 4'h0;
                            end
                        endcase
                    end
                end
                default: state_ff <= SARSEQ_IDLE;
            endcase
        end
    end

    // completion: scan modes report all-done or four-then-rest; continuous per group
    logic done_evt;
    always_comb
    begin
        case (mode)
            SARSEQ_FIX_ONE: done_evt = finish;
            SARSEQ_STEP: done_evt = finish;
            SARSEQ_FIX_CONT, SARSEQ_DUAL: done_evt = finish
                && cnt_ff == (ctrl_ff[`SARSEQ_CTRL_GRP8_BIT] ? 4'h7 : 4'h3);
            default: done_evt = finish && (last_scan
                || (!ctrl_ff[`SARSEQ_CTRL_GRP8_BIT] && nconv_ff == 4'h3));
        endcase
    end

    // result store: continuous modes fill pairs in turn, scan/fixed single use channel pair
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            for (int i = 0; i < 8; i++)
                res_ff[i] <= 10'h000;
        end
        else if (finish)
        begin
            if (mode == SARSEQ_FIX_CONT || mode == SARSEQ_DUAL || mode == SARSEQ_SCAN_CONT)
                res_ff[slot_ff] <= result;
            else
                res_ff[chan_ff] <= result;
        end
    end

    // boundary: early four-msb outside check, then eight-msb, then full for inside
    logic bnd_evt;
    logic [3:0] nb;
    assign nb = bit_ff + 4'h1;
    always_comb
    begin
        bnd_evt = 1'b0;
        if (state_ff == SARSEQ_CONV && tick && ctrl_ff[`SARSEQ_CTRL_BIEN_BIT])
        begin
            if (ctrl_ff[`SARSEQ_CTRL_BOUT_BIT])
            begin
                if (nb == 4'h4 && outside(result, 10'h3C0))
                    bnd_evt = 1'b1;
                else if (nb == 4'h8 && !early_ff && outside(result, 10'h3FC))
                    bnd_evt = 1'b1;
            end
            else if (finish && !outside(result, 10'h3FF))
                bnd_evt = 1'b1;
        end
    end
    always_ff @(posedge clk)
    begin
        if (srst || finish || state_ff != SARSEQ_CONV)
            early_ff <= 1'b0;
        else if (bnd_evt)
            early_ff <= 1'b1;
    end

    // registers; status flags are write-one-to-clear, a new event wins
    assign wr_done_clr = wr && paddr == `SARSEQ_OFF_STAT;
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrl_ff <= `SARSEQ_CTRL_RST;
            chsel_ff <= 8'h00;
            limit_ff <= `SARSEQ_LIMIT_RST;
            done_ff <= 1'b0;
            bndf_ff <= 1'b0;
            bnd_ff <= 8'h00;
        end
        else
        begin
            if (wr && paddr == `SARSEQ_OFF_CTRL)
                ctrl_ff <= {16'h0000, pwdata[15:0]};
            if (wr && paddr == `SARSEQ_OFF_CHSEL)
                chsel_ff <= pwdata[7:0];
            if (wr && paddr == `SARSEQ_OFF_LIMIT)
                limit_ff <= {6'h00, pwdata[25:16], 6'h00, pwdata[9:0]};
            done_ff <= (done_evt & run) | (done_ff & ~(wr_done_clr & pwdata[`SARSEQ_STAT_DONE]));
            bndf_ff <= bnd_evt | (bndf_ff & ~(wr_done_clr & pwdata[`SARSEQ_STAT_BND]));
            for (int i = 0; i < 8; i++)
                bnd_ff[i] <= (bnd_evt && chan_ff == 3'(i))
                    | (bnd_ff[i] & ~(wr && paddr == `SARSEQ_OFF_BND && pwdata[i]));
        end
    end
    // restart of single modes needs run dropped and raised again
    assign done_irq = done_ff & ctrl_ff[`SARSEQ_CTRL_IEN_BIT];
    assign bnd_irq = bndf_ff;

    // read mux, unmapped addresses answer with an error
    always_comb
    begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        case (paddr)
            `SARSEQ_OFF_CTRL: prdata = ctrl_ff;
            `SARSEQ_OFF_CHSEL: prdata = {24'h000000, chsel_ff};
            `SARSEQ_OFF_LIMIT: prdata = limit_ff;
            `SARSEQ_OFF_STAT: prdata = {29'h0, state_ff != SARSEQ_IDLE, bndf_ff, done_ff};
            `SARSEQ_OFF_BND: prdata = {24'h000000, bnd_ff};
            default:
            begin
                if (paddr >= `SARSEQ_OFF_RES0 && paddr < `SARSEQ_OFF_RES0 + 12'h020
                    && paddr[1:0] == 2'b00)
                    prdata = {22'h0, res_ff[paddr[4:2]]};
                else
                    pslverr = psel & penable;
            end
        endcase
        if (!rd)
            prdata = 32'h0000_0000;
    end

    // analog drive
    assign ana.chan = chan_ff;
    assign ana.dac = (state_ff == SARSEQ_CONV) ? trial : 10'h000;
    assign ana.sample = state_ff == SARSEQ_CONV && bit_ff == 4'h0;

    chk_single_stops: assert property (@(posedge clk) disable iff (srst)
        (finish && mode == SARSEQ_FIX_ONE && run) |=> state_ff == SARSEQ_IDLE)
        else $error("single mode did not stop");
    chk_bnd_gate: assert property (@(posedge clk) disable iff (srst)
        !ctrl_ff[`SARSEQ_CTRL_BIEN_BIT] |-> !bnd_evt)
        else $error("boundary event while disabled");
    chk_done_sticky: assert property (@(posedge clk) disable iff (srst)
        (done_ff && !wr_done_clr && run) |=> done_ff)
        else $error("completion flag dropped");
    chk_step_wait: assert property (@(posedge clk) disable iff (srst)
        (finish && mode == SARSEQ_STEP && run) |=> state_ff == SARSEQ_WAIT)
        else $error("step mode did not wait");
    chk_stop_idle: assert property (@(posedge clk) disable iff (srst)
        !run |=> state_ff == SARSEQ_IDLE)
        else $error("stop did not idle");
    chk_pd_hold: assert property (@(posedge clk) disable iff (srst)
        (power_down && state_ff == SARSEQ_CONV) |=> $stable(sar_ff))
        else $error("converter ran in power down");
    chk_edge_start: assert property (@(posedge clk) disable iff (srst)
        (state_ff == SARSEQ_IDLE && run && src == SARSEQ_SRC_EDGE && !go) |=> state_ff != SARSEQ_CONV)
        else $error("start without edge");
    chk_busy_ignore: assert property (@(posedge clk) disable iff (srst)
        (state_ff == SARSEQ_CONV && !finish && run) |=> state_ff == SARSEQ_CONV)
        else $error("conversion broken by trigger");
endmodule : sarseq_top
`default_nettype wire

// >>> tb/sarseq_far_model.sv
// Purpose: far side model: analog levels behind the input mux and timer zero overflow
// Assumes: each channel holds a fixed level; comparator answers within the same clock
// Notes: level sits half a step above its code, so either comparator sense yields it
`timescale 1ns/100ps
`default_nettype none
module sarseq_far_model
(
    input wire logic clk,
    input wire logic srst,
    input wire sarseq_pkg::sarseq_ana_t ana,
    input wire logic tmr_on,
    output logic cmp_above,
    output logic timer0_ovf
);
    import sarseq_pkg::*;
    logic [5:0] tick_ff;
    // settled answer: the sequencer takes it at the same tick as the dac trial
    always_comb
    begin
        cmp_above = (ana.dac <= 10'(ana.chan * 113 + 29));
    end
    // free running timer, overflow pulse every 37 clocks while enabled
    always_ff @(posedge clk)
    begin
        tick_ff <= (srst || tick_ff == 6'h24) ? 6'h00 : tick_ff + 6'h01;
        timer0_ovf <= tmr_on && tick_ff == 6'h24;
    end
endmodule : sarseq_far_model
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: self-checking bench of the scan sequencer over apb
// Assumes: divide by one except in the scan continuous test, so a conversion takes ten clocks
// Notes: status is polled; interrupts are only sampled as levels
`include "sarseq_defines.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
    import sarseq_pkg::*;
    localparam logic [31:0] RUN = 32'h1 << `SARSEQ_CTRL_RUN_BIT;
    localparam logic [31:0] ENB = 32'h1 << `SARSEQ_CTRL_BIT_ENB;
    localparam logic [31:0] GRP8 = 32'h1 << `SARSEQ_CTRL_GRP8_BIT;
    localparam logic [31:0] IEN = 32'h1 << `SARSEQ_CTRL_IEN_BIT;
    localparam logic [31:0] BIEN = 32'h1 << `SARSEQ_CTRL_BIEN_BIT;
    localparam logic [31:0] BOUT = 32'h1 << `SARSEQ_CTRL_BOUT_BIT;
    localparam logic [31:0] EDGE = 32'h1 << `SARSEQ_CTRL_EDGE_BIT;
    logic clk, srst, psel, penable, pwrite, pready, pslverr, timer0_ovf, edge_start_pin;
    logic cmp_above, power_down, done_irq, bnd_irq, tmr_on, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    sarseq_ana_t ana;
    int bad_count, cmp_count, cyc;
    logic [31:0] lim[3] = '{32'h00FF_00F0, 32'h00FE_0000, 32'h03FF_0300};
    logic [31:0] bc[3] = '{BIEN, BOUT, BIEN | BOUT};
    logic be[3] = '{1'b1, 1'b0, 1'b1};

    sarseq_top dut_u (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer0_ovf(timer0_ovf), .edge_start_pin(edge_start_pin),
        .cmp_above(cmp_above), .power_down(power_down), .ana(ana), .done_irq(done_irq),
        .bnd_irq(bnd_irq));
    sarseq_far_model far_u (.clk(clk), .srst(srst), .ana(ana), .tmr_on(tmr_on),
        .cmp_above(cmp_above), .timer0_ovf(timer0_ovf));

    // level each channel presents, in result codes
    function automatic logic [9:0] lvl(input int ch);
        return 10'(ch * 113 + 29);
    endfunction : lvl

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd & m, e)
    endtask : rdchk

    task automatic pair(input int i, input int ch);
        apb(1'b0, 12'(`SARSEQ_OFF_RES0 + 4 * i), 32'h0);
        `CHK(rd[9:0], lvl(ch))
    endtask : pair

    // single modes only restart after run is cleared, so every start clears first
    task automatic go(input logic [31:0] c, input logic [7:0] ch);
        apb(1'b1, `SARSEQ_OFF_CTRL, 32'h0);
        apb(1'b1, `SARSEQ_OFF_STAT, 32'h3);
        apb(1'b1, `SARSEQ_OFF_BND, 32'hFF);
        apb(1'b1, `SARSEQ_OFF_CHSEL, {24'h0, ch});
        apb(1'b1, `SARSEQ_OFF_CTRL, c | ENB);
    endtask : go

    task automatic wait_done();
        int n;
        n = 0;
        rd = 32'h0;
        while (rd[0] !== 1'b1 && n < 400)
        begin
            apb(1'b0, `SARSEQ_OFF_STAT, 32'h0);
            n++;
        end
        `CHK(rd[0], 1'b1)
    endtask : wait_done

    // stop, clear the flag, and make sure nothing completes afterwards
    task automatic stop_run();
        apb(1'b1, `SARSEQ_OFF_CTRL, 32'h0);
        apb(1'b1, `SARSEQ_OFF_STAT, 32'h3);
        repeat (100) @(posedge clk);
        rdchk(`SARSEQ_OFF_STAT, 32'h7, 32'h0);
    endtask : stop_run

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    // clock at 10 MHz
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // hang guard, far above the expected run length
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            bad_count++;
            stop_test();
        end
    end

    // main sequence
    initial
    begin
        {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
        {edge_start_pin, power_down, tmr_on} = 3'h0;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        rdchk(`SARSEQ_OFF_CTRL, 32'hFFFF_FFFF, `SARSEQ_CTRL_RST);
        rdchk(`SARSEQ_OFF_LIMIT, 32'hFFFF_FFFF, `SARSEQ_LIMIT_RST);
        apb(1'b0, 12'h0FC, 32'h0);
        `CHK(err, 1'b1)
        // fixed single on channel 3, held back by power down first
        power_down <= 1'b1;
        go(RUN | IEN | 32'h10, 8'h08);
        repeat (200) @(posedge clk);
        rdchk(`SARSEQ_OFF_STAT, 32'h1, 32'h0);
        power_down <= 1'b0;
        wait_done();
        pair(3, 3);
        `CHK(done_irq, 1'b1)
        // timer start: nothing happens until an overflow arrives
        go(RUN, 8'h40);
        repeat (100) @(posedge clk);
        rdchk(`SARSEQ_OFF_STAT, 32'h5, 32'h0);
        tmr_on <= 1'b1;
        wait_done();
        tmr_on <= 1'b0;
        pair(6, 6);
        // fixed continuous, group of four
        go(RUN | 32'h11, 8'h20);
        wait_done();
        stop_run();
        for (int i = 0; i < 4; i++)
            pair(i, 5);
        // dual channel on 1 and 6, group of eight
        go(RUN | GRP8 | 32'h14, 8'h42);
        wait_done();
        stop_run();
        for (int i = 0; i < 8; i++)
            pair(i, (i % 2) ? 6 : 1);
        // scan continuous over channels 0..5, divide by two, completion after four
        go(RUN | 32'h113, 8'h3F);
        wait_done();
        stop_run();
        for (int i = 0; i < 4; i++)
            pair(i, i);
        // scan single over three channels, then one channel alone
        go(RUN | GRP8 | 32'h12, 8'h94);
        wait_done();
        pair(2, 2);
        pair(4, 4);
        pair(7, 7);
        go(RUN | 32'h12, 8'h02);
        wait_done();
        pair(1, 1);
        // single step on rising edges; a falling edge must not start anything
        go(RUN | IEN | EDGE | 32'h25, 8'h0A);
        repeat (20) @(posedge clk);
        edge_start_pin <= 1'b1;
        wait_done();
        pair(1, 1);
        apb(1'b1, `SARSEQ_OFF_STAT, 32'h1);
        edge_start_pin <= 1'b0;
        repeat (200) @(posedge clk);
        rdchk(`SARSEQ_OFF_STAT, 32'h1, 32'h0);
        edge_start_pin <= 1'b1;
        wait_done();
        pair(3, 3);
        // window checks on channel 2: inside with equality, outside disabled, outside early
        for (int k = 0; k < 3; k++)
        begin
            apb(1'b1, `SARSEQ_OFF_LIMIT, lim[k]);
            go(RUN | bc[k] | 32'h10, 8'h04);
            wait_done();
            rdchk(`SARSEQ_OFF_STAT, 32'h2, {30'h0, be[k], 1'b0});
            rdchk(`SARSEQ_OFF_BND, 32'hFF, be[k] ? 32'h4 : 32'h0);
            `CHK(bnd_irq, be[k])
        end
        stop_test();
    end
endmodule : testbench
`default_nettype wire
